// file: include/role_pkg.sv
// Package for the role resolution block: register map, field layout,
// reset values, timing counts and the carrier structs.
// Assumes a 10 MHz system clock and a 32-bit APB slave port.
package role_pkg;

  // ===========================================================================
  // Register byte offsets.
  localparam logic [7:0] ADV_LOW_OFF = 8'h00;
  localparam logic [7:0] ADV_MID_OFF = 8'h04;
  localparam logic [7:0] NEG_STATUS_OFF = 8'h08;
  localparam logic [7:0] PARTNER_ADV_OFF = 8'h0c;
  localparam logic [7:0] EXTRA_STATUS_OFF = 8'h10;
  localparam logic [7:0] NEG_CTRL_OFF = 8'h14;

  // ===========================================================================
  // Field positions.
  localparam int FORCE_ROLE_BIT = 12;
  localparam int ROLE_PREF_BIT = 4;
  localparam int DONE_BIT = 5;
  localparam int LINK_UP_BIT = 2;
  localparam int PARTNER_FORCE_BIT = 12;
  localparam int PARTNER_PREF_BIT = 20;
  localparam int RESULT_LSB = 0;
  localparam int FAIL_CNT_LSB = 8;
  localparam int RESTART_BIT = 0;
  localparam int ENABLE_BIT = 1;

  // ===========================================================================
  // Role result encoding and reset values.
  localparam logic [1:0] RESULT_NONE = 2'h0;
  localparam logic [1:0] RESULT_SLAVE = 2'h1;
  localparam logic [1:0] RESULT_MASTER = 2'h2;
  localparam logic [1:0] RESULT_FAULT = 2'h3;
  localparam logic RESET_FORCE_ROLE = 1'h0;
  localparam logic RESET_ENABLE = 1'h1;
  localparam logic [15:0] LFSR_SEED = 16'hace1;

  // ===========================================================================
  // Timing: page exchange timeout.
  localparam int CLOCK_HZ = 10_000_000;
  localparam int PAGE_TIMEOUT_MS = 10;
  localparam int PAGE_TIMEOUT_CYC = PAGE_TIMEOUT_MS * (CLOCK_HZ / 1000);

  // ===========================================================================
  // Carrier structs.
  typedef struct packed {
    logic force_role;
    logic role_pref;
  } role_adv_s;

  typedef struct packed {
    logic done;
    logic [1:0] result;
  } role_res_s;

endpackage

// file: rtl/role_resolve.sv
// Combinational role resolution between local and partner advertisements.
// Assumes both advertisements are stable while the caller samples it.
`timescale 1ns/100ps

module role_resolve (
  input wire role_pkg::role_adv_s local_adv_in,
  input wire role_pkg::role_adv_s partner_adv_in,
  input wire logic coin_in,
  output logic [1:0] result_out
);

  // ===========================================================================
  // Resolution table.
  wire both_force = local_adv_in.force_role & partner_adv_in.force_role;
  wire none_force = ~local_adv_in.force_role & ~partner_adv_in.force_role;
  wire same_role = local_adv_in.role_pref == partner_adv_in.role_pref;
  wire clash = both_force & same_role;
  wire be_master_tie = coin_in;
  wire be_master_forced = local_adv_in.force_role ? local_adv_in.role_pref
                                                   : ~partner_adv_in.role_pref;
  wire be_master = (none_force & same_role) ? be_master_tie :
                   none_force ? local_adv_in.role_pref : be_master_forced;

  assign result_out = clash ? role_pkg::RESULT_FAULT :
                      be_master ? role_pkg::RESULT_MASTER : role_pkg::RESULT_SLAVE;

endmodule

// file: rtl/role_negotiator.sv
// Role negotiation for one port of a single-pair PHY, with an APB register
// port. Assumes the page exchange logic delivers the partner's page as a
// one-cycle strobe on the system clock and reports link quality as a level.
//
// The register addresses and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/100ps

module role_negotiator #(
  parameter logic DEFAULT_PREF_MASTER = 1'h1,
  parameter int PAGE_TIMEOUT = role_pkg::PAGE_TIMEOUT_CYC
) (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic page_valid_in,
  input wire role_pkg::role_adv_s page_adv_in,
  input wire logic link_quality_ok_in,
  output role_pkg::role_adv_s local_adv_out,
  output logic page_send_out,
  output logic link_up_out,
  output logic is_master_out
);

  typedef enum logic [1:0] {ST_IDLE, ST_START, ST_EXCHANGE, ST_DONE} neg_state_e;

  // ===========================================================================
  // Registers.
  neg_state_e state_r, state_nxt;
  logic force_role_r;
  logic role_pref_r;
  logic enable_r;
  role_pkg::role_adv_s partner_r;
  role_pkg::role_res_s res_r;
  logic restart_req_r;
  logic [31:0] timer_r;
  logic [15:0] lfsr_r;
  logic [7:0] fail_cnt_r;
  logic [1:0] resolved;
  logic [31:0] rdata;

  // ===========================================================================
  // Bus decode.
  wire access = psel_in & penable_in;
  wire wr = access & pwrite_in;
  wire hit_low = paddr_in == role_pkg::ADV_LOW_OFF;
  wire hit_mid = paddr_in == role_pkg::ADV_MID_OFF;
  wire hit_stat = paddr_in == role_pkg::NEG_STATUS_OFF;
  wire hit_part = paddr_in == role_pkg::PARTNER_ADV_OFF;
  wire hit_extra = paddr_in == role_pkg::EXTRA_STATUS_OFF;
  wire hit_ctrl = paddr_in == role_pkg::NEG_CTRL_OFF;
  wire mapped = hit_low | hit_mid | hit_stat | hit_part | hit_extra | hit_ctrl;
  wire wr_low = wr & hit_low;
  wire wr_mid = wr & hit_mid;
  wire wr_ctrl = wr & hit_ctrl;
  wire sw_restart = wr_ctrl & pwdata_in[role_pkg::RESTART_BIT];
  // Writing an advertisement restarts negotiation so the partner sees it.
  wire adv_changed = wr_low | wr_mid;

  assign pready_out = 1'h1;
  assign pslverr_out = access & ~mapped;

  wire [31:0] part_word = res_r.done ?
      (32'h0 | (32'(partner_r.force_role) << role_pkg::PARTNER_FORCE_BIT)
             | (32'(partner_r.role_pref) << role_pkg::PARTNER_PREF_BIT)) : 32'h0;
  wire [31:0] extra_word = (res_r.done ? 32'(res_r.result) << role_pkg::RESULT_LSB : 32'h0)
                         | (32'(fail_cnt_r) << role_pkg::FAIL_CNT_LSB);
  wire [31:0] stat_word = (32'(res_r.done) << role_pkg::DONE_BIT)
                        | (32'(link_up_out) << role_pkg::LINK_UP_BIT);
  wire [31:0] low_word = 32'(force_role_r) << role_pkg::FORCE_ROLE_BIT;
  wire [31:0] mid_word = 32'(role_pref_r) << role_pkg::ROLE_PREF_BIT;
  wire [31:0] ctrl_word = 32'(enable_r) << role_pkg::ENABLE_BIT;

  always_comb begin
    rdata = 32'h0;
    if (hit_low) begin
      rdata = low_word;
    end
    if (hit_mid) begin
      rdata = mid_word;
    end
    if (hit_stat) begin
      rdata = stat_word;
    end
    if (hit_part) begin
      rdata = part_word;
    end
    if (hit_extra) begin
      rdata = extra_word;
    end
    if (hit_ctrl) begin
      rdata = ctrl_word;
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      prdata_out <= 32'h0;
    end else if (psel_in & ~penable_in & ~pwrite_in) begin
      prdata_out <= rdata;
    end
  end

  // ===========================================================================
  // Advertisement registers.
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      role_pref_r <= DEFAULT_PREF_MASTER;
      force_role_r <= role_pkg::RESET_FORCE_ROLE;
      enable_r <= role_pkg::RESET_ENABLE;
    end else begin
      if (wr_low) begin
        force_role_r <= pwdata_in[role_pkg::FORCE_ROLE_BIT];
      end
      if (wr_mid) begin
        role_pref_r <= pwdata_in[role_pkg::ROLE_PREF_BIT];
      end
      if (wr_ctrl) begin
        enable_r <= pwdata_in[role_pkg::ENABLE_BIT];
      end
    end
  end

  assign local_adv_out.force_role = force_role_r;
  assign local_adv_out.role_pref = role_pref_r;

  // ===========================================================================
  // Pseudo-random source.
  // free-running lfsr
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      lfsr_r <= role_pkg::LFSR_SEED;
    end else begin
      lfsr_r <= {lfsr_r[14:0], lfsr_r[15] ^ lfsr_r[13] ^ lfsr_r[12] ^ lfsr_r[10]};
    end
  end

  role_resolve u_resolve (
    .local_adv_in(local_adv_out),
    .partner_adv_in(page_adv_in),
    .coin_in(lfsr_r[0]),
    .result_out(resolved)
  );

  // ===========================================================================
  // Negotiation sequencer.
  // failure causes
  wire timed_out = timer_r >= 32'(PAGE_TIMEOUT - 1);
  wire fault = resolved == role_pkg::RESULT_FAULT;
  wire fail_now = (state_r == ST_EXCHANGE) &
                  ((page_valid_in & fault) | ~link_quality_ok_in | timed_out);
  wire good_page = (state_r == ST_EXCHANGE) & page_valid_in & ~fault & link_quality_ok_in;
  wire restart_any = restart_req_r | sw_restart | adv_changed;

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_IDLE: begin
        if (enable_r) begin
          state_nxt = ST_START;
        end
      end
      ST_START: begin
        state_nxt = ST_EXCHANGE;
      end
      ST_EXCHANGE: begin
        if (fail_now) begin
          state_nxt = ST_START;
        end else if (good_page) begin
          state_nxt = ST_DONE;
        end
      end
      ST_DONE: begin
        if (~link_quality_ok_in) begin
          state_nxt = ST_START;
        end
      end
    endcase
    if (~enable_r) begin
      state_nxt = ST_IDLE;
    end else if (restart_any & (state_r != ST_IDLE)) begin
      state_nxt = ST_START;
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      state_r <= ST_IDLE;
      restart_req_r <= 1'h0;
      timer_r <= 32'h0;
      fail_cnt_r <= 8'h0;
    end else begin
      state_r <= state_nxt;
      restart_req_r <= 1'h0;
      timer_r <= (state_r == ST_EXCHANGE) ? timer_r + 32'h1 : 32'h0;
      if (fail_now & (fail_cnt_r != 8'hff)) begin
        fail_cnt_r <= fail_cnt_r + 8'h1;
      end
    end
  end

  // Partner bits and result are captured only on a page, after START has
  // already dropped done, so software never sees stale data flagged valid.
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      partner_r <= '0;
      res_r <= '0;
    end else if (state_nxt == ST_START || state_nxt == ST_IDLE) begin
      res_r.done <= 1'h0;
    end else if ((state_r == ST_EXCHANGE) & page_valid_in) begin
      partner_r <= page_adv_in;
      res_r.result <= resolved;
      res_r.done <= good_page;
    end
  end

  assign link_up_out = (state_r == ST_DONE) & res_r.done;
  assign is_master_out = link_up_out & (res_r.result == role_pkg::RESULT_MASTER);
  assign page_send_out = state_r == ST_START;

endmodule

// file: sim/role_negotiator_chk.sv
// Concurrent checks on the ports of the role negotiator.
// Assumes one clock domain with a synchronous active-high reset.
`timescale 1ns/100ps
module role_negotiator_chk (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic [7:0] paddr_in,
  input wire logic pslverr_out,
  input wire logic page_valid_in,
  input wire role_pkg::role_adv_s page_adv_in,
  input wire logic link_quality_ok_in,
  input wire role_pkg::role_adv_s local_adv_out,
  input wire logic page_send_out,
  input wire logic link_up_out,
  input wire logic is_master_out
);
  // ===========================================================================
  // Assertions.
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in);
  a_master_has_link: assert property (is_master_out |-> link_up_out)
    else $error("master without link");
  a_send_link_down: assert property (page_send_out |-> !link_up_out)
    else $error("link up while sending page");
  a_quality_drop: assert property (link_up_out && !link_quality_ok_in |=> !link_up_out)
    else $error("link held on poor quality");
  a_up_after_page: assert property ($rose(link_up_out) |-> $past(page_valid_in))
    else $error("link rose without page");
  a_no_equal_forced: assert property ($rose(link_up_out) |-> !(local_adv_out.force_role &&
    $past(page_adv_in.force_role) && local_adv_out.role_pref == $past(page_adv_in.role_pref)))
    else $error("link up on fault");
  a_local_forced: assert property ($rose(link_up_out) && local_adv_out.force_role &&
    !$past(page_adv_in.force_role) |-> is_master_out == local_adv_out.role_pref)
    else $error("local forced role lost");
  a_partner_forced: assert property ($rose(link_up_out) && !local_adv_out.force_role &&
    $past(page_adv_in.force_role) |-> is_master_out == !$past(page_adv_in.role_pref))
    else $error("partner forced role lost");
  a_pref_differs: assert property ($rose(link_up_out) && !local_adv_out.force_role &&
    !$past(page_adv_in.force_role) && local_adv_out.role_pref != $past(page_adv_in.role_pref)
    |-> is_master_out == local_adv_out.role_pref) else $error("preference ignored");
  a_unmapped_err: assert property (psel_in && penable_in && paddr_in > 8'h14 |-> pslverr_out)
    else $error("unmapped access not refused");
endmodule

bind role_negotiator role_negotiator_chk chk_u (.clock_in(clock_in), .rst_in(rst_in),
  .psel_in(psel_in), .penable_in(penable_in), .paddr_in(paddr_in), .pslverr_out(pslverr_out),
  .page_valid_in(page_valid_in), .page_adv_in(page_adv_in),
  .link_quality_ok_in(link_quality_ok_in), .local_adv_out(local_adv_out),
  .page_send_out(page_send_out), .link_up_out(link_up_out), .is_master_out(is_master_out));

// file: sim/link_partner_model.sv
// Far-end negotiator: answers each local page with its own page after a delay, unless mute_in is high.
// Assumes the bench changes its advertisement only while no page is pending.
`timescale 1ns/100ps
module link_partner_model (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic page_send_in,
  input wire role_pkg::role_adv_s adv_in,
  input wire logic [3:0] delay_in,
  input wire logic mute_in,
  output logic page_valid_out,
  output role_pkg::role_adv_s page_adv_out
);
  int wait_cnt = 0;
  role_pkg::role_adv_s last_adv = '0;
  initial page_valid_out = 1'b0;
  // ===========================================================================
  // forced or preferred role.
  // Between pages the lines show the inverse of the last page, never a stale copy.
  always @(posedge clock_in) begin
    page_valid_out <= 1'b0;
    page_adv_out <= ~last_adv;
    if (rst_in) begin
      wait_cnt <= 0;
    end else if (page_send_in && !mute_in) begin
      wait_cnt <= delay_in + 1;
    end else if (wait_cnt == 1) begin
      page_valid_out <= 1'b1;
      page_adv_out <= adv_in;
      last_adv <= adv_in;
      wait_cnt <= 0;
    end else if (wait_cnt > 0) begin
      wait_cnt <= wait_cnt - 1;
    end
  end
endmodule

// file: sim/role_negotiator_tb_top.sv
// Self-checking bench for the role negotiator with a far-end model.
// Assumes the page timeout parameter is shortened to 50 cycles.
`timescale 1ns/100ps
module role_negotiator_tb_top;
  logic clock_in = 1'b0;
  logic rst_in = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, quality = 1'b1, mute = 1'b0;
  logic [7:0] paddr = 8'h00, fails;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err, page_valid, page_send, link_up, is_master;
  logic [3:0] delay = 4'h3;
  role_pkg::role_adv_s page_adv, local_adv, far_adv = '0;
  int miscompares = 0, cmp_count = 0, cycles = 0, seed = 667;

  always #50 clock_in = ~clock_in;

  role_negotiator #(.DEFAULT_PREF_MASTER(1'h1), .PAGE_TIMEOUT(50)) dut_u (
    .clock_in(clock_in), .rst_in(rst_in), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr), .page_valid_in(page_valid),
    .page_adv_in(page_adv), .link_quality_ok_in(quality), .local_adv_out(local_adv),
    .page_send_out(page_send), .link_up_out(link_up), .is_master_out(is_master));

  link_partner_model far_u (.clock_in(clock_in), .rst_in(rst_in), .page_send_in(page_send),
    .adv_in(far_adv), .delay_in(delay), .mute_in(mute), .page_valid_out(page_valid),
    .page_adv_out(page_adv));

  // ===========================================================================
  // Shared tasks.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] data);
    @(posedge clock_in);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= data;
    @(posedge clock_in);
    penable <= 1'b1;
    @(posedge clock_in);
    while (pready !== 1'b1) @(posedge clock_in);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  function automatic logic [1:0] exp_role(input logic lf, lp, pf, pp);
    if (lf && pf && lp == pp) return role_pkg::RESULT_FAULT;
    if (lf) return lp ? role_pkg::RESULT_MASTER : role_pkg::RESULT_SLAVE;
    if (pf) return pp ? role_pkg::RESULT_SLAVE : role_pkg::RESULT_MASTER;
    if (lp != pp) return lp ? role_pkg::RESULT_MASTER : role_pkg::RESULT_SLAVE;
    return role_pkg::RESULT_NONE;
  endfunction

  // One negotiation; c holds local force, local pref, partner force, partner pref.
  task automatic negotiate(input logic [3:0] c);
    logic [1:0] exp;
    int n;
    exp = exp_role(c[3], c[2], c[1], c[0]);
    far_adv <= c[1:0];
    delay <= 4'h3 + 4'($random(seed) & 3);
    apb(1'b1, role_pkg::ADV_LOW_OFF, 32'(c[3]) << role_pkg::FORCE_ROLE_BIT);
    apb(1'b1, role_pkg::ADV_MID_OFF, 32'(c[2]) << role_pkg::ROLE_PREF_BIT);
    apb(1'b0, role_pkg::NEG_STATUS_OFF, 32'h0);
    check(rd[role_pkg::DONE_BIT], 1'b0);
    apb(1'b0, role_pkg::EXTRA_STATUS_OFF, 32'h0);
    fails = rd[15:8];
    n = 0;
    while (link_up !== 1'b1 && n < 40) begin
      @(posedge clock_in);
      n++;
    end
    apb(1'b0, role_pkg::NEG_STATUS_OFF, 32'h0);
    check(rd[role_pkg::DONE_BIT], exp != role_pkg::RESULT_FAULT);
    check(rd[role_pkg::LINK_UP_BIT], exp != role_pkg::RESULT_FAULT);
    apb(1'b0, role_pkg::EXTRA_STATUS_OFF, 32'h0);
    if (exp == role_pkg::RESULT_FAULT) check(rd[15:8] != fails, 1'b1);
    else if (exp == role_pkg::RESULT_NONE) check(rd[1] ^ rd[0], 1'b1);
    else check(rd[1:0], exp);
    if (exp != role_pkg::RESULT_FAULT) begin
      check(is_master, rd[1:0] == role_pkg::RESULT_MASTER);
      apb(1'b0, role_pkg::PARTNER_ADV_OFF, 32'h0);
      check({rd[role_pkg::PARTNER_FORCE_BIT], rd[role_pkg::PARTNER_PREF_BIT]}, c[1:0]);
    end
  endtask

  // ===========================================================================
  // Main sequence and timeout.
  always @(posedge clock_in) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      end_of_test;
    end
  end

  initial begin
    repeat (12) @(posedge clock_in);
    rst_in <= 1'b0;
    apb(1'b0, role_pkg::ADV_LOW_OFF, 32'h0);
    check(rd, 32'h0);
    apb(1'b0, role_pkg::ADV_MID_OFF, 32'h0);
    check(rd, 32'h10);
    apb(1'b0, role_pkg::NEG_CTRL_OFF, 32'h0);
    check(rd, 32'h2);
    apb(1'b1, 8'h20, 32'hffffffff);
    check(err, 1'b1);
    apb(1'b0, 8'h20, 32'h0);
    check(err, 1'b1);
    check(rd, 32'h0);
    for (int i = 0; i < 16; i++) negotiate(4'(i));
    repeat (8) negotiate(4'($random(seed)));
    negotiate(4'h8);
    quality <= 1'b0;
    repeat (2) @(posedge clock_in);
    @(negedge clock_in);
    check(link_up, 1'b0);
    @(posedge clock_in);
    quality <= 1'b1;
    mute <= 1'b1;
    apb(1'b1, role_pkg::NEG_CTRL_OFF, 32'h3);
    apb(1'b0, role_pkg::EXTRA_STATUS_OFF, 32'h0);
    fails = rd[15:8];
    repeat (120) @(posedge clock_in);
    apb(1'b0, role_pkg::EXTRA_STATUS_OFF, 32'h0);
    check(rd[15:8] != fails, 1'b1);
    check(link_up, 1'b0);
    end_of_test;
  end
endmodule
